/* File: deser_strap_config_mux.sv */
// shared-pin and power-up strap logic of a serial-link video receiver
// assumes pads resolve open-drain enables and hold weak pulldowns;
// inputs from pins are asynchronous and pass a two-stage synchroniser

// Notes on behaviour
// - enable strap low at power-up: control channel off, shared pins are straps
// - all strap states captured once after reset, held until next reset
// - channel enabled: mode-select low is base mode, high is bypass
// - channel disabled: dual-output strap low single, high double
// - channel disabled: bus-width strap low 24-bit, high 32-bit word
// - channel disabled: sync-encode strap low off, high on
// - channel disabled: error-correct strap low off, high on
// - channel disabled: edge strap low rising edge, high falling edge
// - unconnected two-level inputs read low, pulldown held by the pad
// - general input change reaches far-end output within 0.35 ms
// - channel enabled: general output 0 pulls pin low, 1 releases; pin level always readable
module deser_strap_config_mux (
  // clock and reset
  input  wire logic MCLK_I,
  input  wire logic SYS_RST_I,
  // configuration and mode pins
  input  wire logic LOCAL_CTRL_CHAN_ENABLE_I,
  input  wire logic MODE_SELECT_PIN_I,
  // shared pin 0 : general_io_zero / dual_output_strap
  input  wire logic GENERAL_IO_ZERO_I,
  output logic      GENERAL_IO_ZERO_O,
  output logic      GENERAL_IO_ZERO_OE_O,
  // shared pin 1 : general_io_one / bus_width_strap
  input  wire logic GENERAL_IO_ONE_I,
  output logic      GENERAL_IO_ONE_O,
  output logic      GENERAL_IO_ONE_OE_O,
  // shared rx / err_correct_strap and tx / edge_select_strap pins
  input  wire logic RX_PIN_I,
  output logic      RX_PIN_O,
  output logic      RX_PIN_OE_O,
  input  wire logic TX_PIN_I,
  output logic      TX_PIN_O,
  output logic      TX_PIN_OE_O,
  // control channel side (open-drain drive requests)
  input  wire logic CHAN_RX_PULL_LOW_I,
  input  wire logic CHAN_TX_PULL_LOW_I,
  output logic      CHAN_RX_LEVEL_O,
  output logic      CHAN_TX_LEVEL_O,
  // general output bits written by the control channel
  input  wire logic GEN_OUT_ZERO_WR_I,
  input  wire logic GEN_OUT_ONE_WR_I,
  input  wire logic GEN_OUT_WR_EN_I,
  output logic      GEN_IN_ZERO_O,
  output logic      GEN_IN_ONE_O,
  // general input forwarding
  input  wire logic GEN_INPUT_LINE_I,
  output logic      GEN_OUTPUT_LINE_O,
  // latched configuration
  output logic      CHAN_ENABLED_O,
  output logic      BYPASS_MODE_O,
  output logic      DOUBLE_OUTPUT_O,
  output logic      WIDE_WORD_O,
  output logic      SYNC_ENCODE_O,
  output logic      ERR_CORRECT_O,
  output logic      FALLING_EDGE_O,
  output logic      CONFIG_VALID_O
);

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  // order: 6 gpi, 5 tx, 4 rx, 3 io1, 2 io0, 1 ms, 0 enable
  logic [6:0] pins_raw;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] sync1_next;
  logic [6:0] sync2_next;

  assign pins_raw = {GEN_INPUT_LINE_I, TX_PIN_I, RX_PIN_I, GENERAL_IO_ONE_I,
                     GENERAL_IO_ZERO_I, MODE_SELECT_PIN_I, LOCAL_CTRL_CHAN_ENABLE_I};

  // first stage feeds only the second stage
  always_comb begin
    sync1_next = pins_raw;
    sync2_next = sync1_reg;
  end

  // floating pins read low thanks to pad pulldowns
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ---------------------------------------------
  // power-up capture
  // ---------------------------------------------
  strap_cfg_pkg::cap_state_e state_reg;
  strap_cfg_pkg::cap_state_e state_next;
  logic [3:0] settle_reg;
  logic [3:0] settle_next;
  logic [5:0] cfg_reg;   // 5 en, 4 dbl, 3 bws, 2 sync_encode_strap, 1 edc, 0 es
  logic [5:0] cfg_next;
  logic       ms_reg;
  logic       ms_next;
  logic       valid_reg;
  logic       valid_next;

  // straps are taken once, after the synchroniser has filled
  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    cfg_next    = cfg_reg;
    ms_next     = ms_reg;
    unique case (state_reg)
      strap_cfg_pkg::ST_SETTLE: begin
        if (settle_reg == 4'h0) begin
          state_next = strap_cfg_pkg::ST_SAMPLE;
        end else begin
          settle_next = settle_reg - 4'h1;
        end
      end
      strap_cfg_pkg::ST_SAMPLE: begin
        cfg_next[5] = sync2_reg[0];
        if (sync2_reg[0]) begin
          cfg_next[4:0] = 5'h00;                                     // straps unused
        end else begin
          cfg_next[4:0] = {sync2_reg[2], sync2_reg[3], sync2_reg[1],
                           sync2_reg[4], sync2_reg[5]};
        end
        state_next = strap_cfg_pkg::ST_RUN;
      end
      strap_cfg_pkg::ST_RUN: begin
        state_next = strap_cfg_pkg::ST_RUN;                          // held until reset
      end
      default: begin
        state_next = strap_cfg_pkg::ST_SETTLE;
      end
    endcase
    // mode select follows its pin only with the channel on
    if (state_reg == strap_cfg_pkg::ST_RUN) begin
      ms_next = cfg_reg[5] & sync2_reg[1];
    end
    // registered so the valid pin comes straight from a flop, same timing as the state
    valid_next = (state_next == strap_cfg_pkg::ST_RUN);
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg  <= strap_cfg_pkg::ST_SETTLE;
      settle_reg <= strap_cfg_pkg::SETTLE_LOAD;
      cfg_reg    <= {6{strap_cfg_pkg::STRAP_RESET}};
      ms_reg     <= strap_cfg_pkg::STRAP_RESET;
      valid_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
      cfg_reg    <= cfg_next;
      ms_reg     <= ms_next;
      valid_reg  <= valid_next;
    end
  end

  logic run_en;
  assign run_en = (state_reg == strap_cfg_pkg::ST_RUN) & cfg_reg[5];

  // ---------------------------------------------
  // general I/O and shared serial pins
  // ---------------------------------------------
  logic [1:0] gout_reg;
  logic [1:0] gout_next;
  logic [5:0] pad_reg;   // 5 io0 oe, 4 io1 oe, 3 rx oe, 2 tx oe, 1 rx lvl, 0 tx lvl
  logic [5:0] pad_next;
  logic [1:0] gin_reg;
  logic [1:0] gin_next;

  // open-drain: drive low only, so the data outputs stay 0 and only oe moves
  always_comb begin
    gout_next = gout_reg;
    if (GEN_OUT_WR_EN_I) begin
      gout_next = {GEN_OUT_ONE_WR_I, GEN_OUT_ZERO_WR_I};
    end
    pad_next[5] = run_en & ~gout_reg[0];
    pad_next[4] = run_en & ~gout_reg[1];
    pad_next[3] = run_en & CHAN_RX_PULL_LOW_I;
    pad_next[2] = run_en & CHAN_TX_PULL_LOW_I;
    pad_next[1] = sync2_reg[4] | ~run_en;                            // idle high when off
    pad_next[0] = sync2_reg[5] | ~run_en;
    gin_next    = {sync2_reg[3], sync2_reg[2]};                      // always readable
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      gout_reg <= {2{strap_cfg_pkg::GPIO_OUT_RESET}};
      pad_reg  <= 6'h03;
      gin_reg  <= 2'h0;
    end else begin
      gout_reg <= gout_next;
      pad_reg  <= pad_next;
      gin_reg  <= gin_next;
    end
  end

  // ---------------------------------------------
  // general input forwarding
  // ---------------------------------------------
  // a short fixed delay models link transport; changes closer than the
  // delay restart it, which the driver's spacing rule makes harmless
  logic       fwd_seen_reg;
  logic       fwd_seen_next;
  logic [4:0] fwd_cnt_reg;
  logic [4:0] fwd_cnt_next;
  logic       gpo_reg;
  logic       gpo_next;

  always_comb begin
    fwd_seen_next = sync2_reg[6];
    fwd_cnt_next  = fwd_cnt_reg;
    gpo_next      = gpo_reg;
    if (sync2_reg[6] != fwd_seen_reg) begin
      fwd_cnt_next = strap_cfg_pkg::FWD_DELAY_LOAD;
    end else if (fwd_cnt_reg != 5'h00) begin
      fwd_cnt_next = fwd_cnt_reg - 5'h01;
    end else begin
      gpo_next = fwd_seen_reg;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fwd_seen_reg <= 1'b0;
      fwd_cnt_reg  <= 5'h00;
      gpo_reg      <= 1'b0;
    end else begin
      fwd_seen_reg <= fwd_seen_next;
      fwd_cnt_reg  <= fwd_cnt_next;
      gpo_reg      <= gpo_next;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign GENERAL_IO_ZERO_O    = 1'b0;
  assign GENERAL_IO_ONE_O     = 1'b0;
  assign RX_PIN_O             = 1'b0;
  assign TX_PIN_O             = 1'b0;
  assign GENERAL_IO_ZERO_OE_O = pad_reg[5];
  assign GENERAL_IO_ONE_OE_O  = pad_reg[4];
  assign RX_PIN_OE_O          = pad_reg[3];
  assign TX_PIN_OE_O          = pad_reg[2];
  assign CHAN_RX_LEVEL_O      = pad_reg[1];
  assign CHAN_TX_LEVEL_O      = pad_reg[0];
  assign GEN_IN_ZERO_O        = gin_reg[0];
  assign GEN_IN_ONE_O         = gin_reg[1];
  assign GEN_OUTPUT_LINE_O    = gpo_reg;
  assign CHAN_ENABLED_O       = cfg_reg[5];
  assign BYPASS_MODE_O        = ms_reg;
  assign DOUBLE_OUTPUT_O      = cfg_reg[4];
  assign WIDE_WORD_O          = cfg_reg[3];
  assign SYNC_ENCODE_O        = cfg_reg[2];
  assign ERR_CORRECT_O        = cfg_reg[1];
  assign FALLING_EDGE_O       = cfg_reg[0];
  assign CONFIG_VALID_O       = valid_reg;

  // ---------------------------------------------
  // assertion helper: cycles since the forwarded level last moved
  // ---------------------------------------------
  logic [4:0] fwd_age_reg;
  logic [4:0] fwd_age_next;

  // saturates so a long quiet spell cannot wrap back below the window
  always_comb begin
    fwd_age_next = fwd_age_reg;
    if (fwd_seen_next != fwd_seen_reg) begin
      fwd_age_next = 5'h00;
    end else if (fwd_age_reg != 5'h1F) begin
      fwd_age_next = fwd_age_reg + 5'h01;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fwd_age_reg <= 5'h00;
    end else begin
      fwd_age_reg <= fwd_age_next;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_cfg_held: assert property (CONFIG_VALID_O && $past(CONFIG_VALID_O) |-> $stable(cfg_reg))
    else $error("latched configuration changed after capture");
  chk_straps_off: assert property (CONFIG_VALID_O && cfg_reg[5] |-> cfg_reg[4:0] == 5'h00)
    else $error("straps latched while channel enabled");
  chk_strap_map: assert property (state_reg == strap_cfg_pkg::ST_SAMPLE && !sync2_reg[0]
      |=> cfg_reg[4:0] == $past({sync2_reg[2], sync2_reg[3], sync2_reg[1], sync2_reg[4], sync2_reg[5]}))
    else $error("strap values mapped wrongly");
  chk_wide_word: assert property (state_reg == strap_cfg_pkg::ST_SAMPLE && !sync2_reg[0]
      |=> WIDE_WORD_O == $past(sync2_reg[3]))
    else $error("bus width strap wrong");
  chk_bypass_gate: assert property (!cfg_reg[5] |-> !BYPASS_MODE_O)
    else $error("bypass set with channel disabled");
  chk_mode_follow: assert property (run_en ##1 run_en |-> BYPASS_MODE_O == $past(sync2_reg[1]))
    else $error("mode select not followed");
  chk_pads_quiet: assert property (!cfg_reg[5] |-> !(GENERAL_IO_ZERO_OE_O || GENERAL_IO_ONE_OE_O
      || RX_PIN_OE_O || TX_PIN_OE_O))
    else $error("shared pin driven while used as strap");
  chk_gpio_drive: assert property (run_en ##1 run_en |-> GENERAL_IO_ZERO_OE_O == !$past(gout_reg[0]))
    else $error("general output drive mismatch");
  chk_fwd_bound: assert property (fwd_age_reg >= 5'(strap_cfg_pkg::FWD_DELAY_CYCLES)
      |-> GEN_OUTPUT_LINE_O == fwd_seen_reg)
    else $error("general input not forwarded in time");
  chk_gin_read: assert property (GEN_IN_ONE_O == $past(sync2_reg[3]))
    else $error("general input level not readable");

  cov_strap_mode: cover property (CONFIG_VALID_O && !CHAN_ENABLED_O);
  cov_chan_mode:  cover property (CONFIG_VALID_O && CHAN_ENABLED_O && BYPASS_MODE_O);
  cov_forward:    cover property ($rose(GEN_OUTPUT_LINE_O));
  cov_gpio_low:   cover property (GENERAL_IO_ONE_OE_O);

endmodule : deser_strap_config_mux

/* File: strap_cfg_pkg.sv */
// package for the power-up strap and shared-pin selection block
// assumes a single 40 MHz clock and no software-reachable registers
package strap_cfg_pkg;

  // ---------------------------------------------
  // clock and timing
  // ---------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 25000;   // 40 MHz
  localparam int unsigned FWD_MAX_TIME_US  = 350;     // 0.35 ms forwarding bound
  localparam int unsigned FWD_MAX_CYCLES   = (FWD_MAX_TIME_US * 1000000) / CLK_PERIOD_PS;
  // forwarding latency used by the block, well inside the bound
  localparam int unsigned FWD_DELAY_CYCLES = 16;
  localparam logic [4:0]  FWD_DELAY_LOAD   = 5'h0F;   // delay - 1
  // cycles after reset release before straps are sampled (pins settled)
  localparam logic [3:0]  SETTLE_LOAD      = 4'h7;

  // ---------------------------------------------
  // reset values of latched configuration
  // ---------------------------------------------
  localparam logic        STRAP_RESET      = 1'b0;    // pulldown default
  localparam logic        GPIO_OUT_RESET   = 1'b1;    // released

  // ---------------------------------------------
  // state machine
  // ---------------------------------------------
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b11
  } cap_state_e;

endpackage : strap_cfg_pkg

/* File: strap_board_model.sv */
// board-side model: strap resistors, far-end drivers and open-drain pins
// assumes the design raises an enable while it pulls its pin low
module strap_board_model (
  // design pull-low requests
  input  wire logic [3:0] pull_low_i,
  // board drivers and resistor choice
  input  wire logic [3:0] drive_en_i,
  input  wire logic [3:0] drive_val_i,
  input  wire logic       pull_up_i,
  // resolved pin levels
  output logic      [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // wired-and pin resolution
  // ---------------------------------------------
  // any party pulling low wins; never leave a pin floating to x
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pull_low_i[i] || (drive_en_i[i] && !drive_val_i[i])) begin
        pin_o[i] = 1'b0;
      end else if (drive_en_i[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = pull_up_i; // pulldown unless a pullup is fitted
      end
    end
  end
endmodule : strap_board_model

/* File: deser_strap_config_mux_tb_top.sv */
// self-checking bench for the strap and shared-pin block
// assumes the board model resolves all four shared pins
module deser_strap_config_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int idx; logic exp; int left;} note_s;
  // ---------------------------------------------
  // stimulus, observation and bookkeeping
  // ---------------------------------------------
  logic            mclk = 1'b0, rst = 1'b1, en = 1'b0, mode = 1'b0, pu = 1'b0;
  logic            rx_pl = 1'b0, tx_pl = 1'b0, wz = 1'b1, wo = 1'b1, wen = 1'b0, gen_input_line = 1'b0;
  logic      [3:0] den = 4'h0, dval = 4'h0;
  logic      [4:0] s;
  wire logic [3:0] pin, oe, dout;
  wire logic [16:0] obs;
  note_s           q[$];
  int              fail_count = 0, n_checks = 0;

  always #12.5 mclk = ~mclk;

  deser_strap_config_mux uut (
    .MCLK_I(mclk), .SYS_RST_I(rst), .LOCAL_CTRL_CHAN_ENABLE_I(en), .MODE_SELECT_PIN_I(mode),
    .GENERAL_IO_ZERO_I(pin[0]), .GENERAL_IO_ZERO_O(dout[0]), .GENERAL_IO_ZERO_OE_O(oe[0]),
    .GENERAL_IO_ONE_I(pin[1]), .GENERAL_IO_ONE_O(dout[1]), .GENERAL_IO_ONE_OE_O(oe[1]),
    .RX_PIN_I(pin[2]), .RX_PIN_O(dout[2]), .RX_PIN_OE_O(oe[2]),
    .TX_PIN_I(pin[3]), .TX_PIN_O(dout[3]), .TX_PIN_OE_O(oe[3]),
    .CHAN_RX_PULL_LOW_I(rx_pl), .CHAN_TX_PULL_LOW_I(tx_pl),
    .CHAN_RX_LEVEL_O(obs[10]), .CHAN_TX_LEVEL_O(obs[11]),
    .GEN_OUT_ZERO_WR_I(wz), .GEN_OUT_ONE_WR_I(wo), .GEN_OUT_WR_EN_I(wen),
    .GEN_IN_ZERO_O(obs[8]), .GEN_IN_ONE_O(obs[9]),
    .GEN_INPUT_LINE_I(gen_input_line), .GEN_OUTPUT_LINE_O(obs[12]),
    .CHAN_ENABLED_O(obs[0]), .BYPASS_MODE_O(obs[1]), .DOUBLE_OUTPUT_O(obs[2]), .WIDE_WORD_O(obs[3]),
    .SYNC_ENCODE_O(obs[4]), .ERR_CORRECT_O(obs[5]), .FALLING_EDGE_O(obs[6]), .CONFIG_VALID_O(obs[7])
  );
  assign obs[16:13] = oe;

  // a driven pin only pulls low when its data output is really low
  strap_board_model board (.pull_low_i(oe & ~dout), .drive_en_i(den), .drive_val_i(dval), .pull_up_i(pu),
                           .pin_o(pin));

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic wrap_up;
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input int idx, input logic exp, input logic seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED obs[%0d] expected %b seen %b", idx, exp, seen);
    end
  endtask : check

  // expected level of one watched output, allowed to arrive within left cycles
  task automatic note(input int idx, input logic exp, input int left);
    q.push_back('{idx, exp, left});
  endtask : note

  // waits for the monitor to use up all notes; bounded so a hang fails
  task automatic drain;
    int n;
    n = 0;
    while (q.size() != 0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    if (q.size() != 0) begin
      fail_count++;
      wrap_up();
    end
    #2;
  endtask : drain

  task automatic power_up(input logic e, input logic [4:0] st, input logic d, input logic p);
    rst = 1'b1;
    en = e;
    mode = st[2];
    dval = {st[4], st[3], st[1], st[0]};
    den = {4{d}};
    pu = p;
    repeat (10) @(posedge mclk);
    #2 rst = 1'b0;
    note(7, 1'b1, 15);
  endtask : power_up

  task automatic wr(input logic z, input logic o);
    wz = z;
    wo = o;
    wen = 1'b1;
    @(posedge mclk);
    #2 wen = 1'b0;
  endtask : wr

  // ---------------------------------------------
  // monitor: oldest note against the outputs
  // ---------------------------------------------
  // sampled on the falling edge so registered outputs have settled
  always @(negedge mclk) begin
    if (q.size() != 0) begin
      if (obs[q[0].idx] === q[0].exp || q[0].left <= 0) begin
        check(q[0].idx, q[0].exp, obs[q[0].idx]);
        void'(q.pop_front());
      end else begin
        q[0].left = q[0].left - 1;
      end
    end
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(32'h9e877bbf));
    #2;
    // channel off: random straps, last pass leaves all four shared pins unconnected
    for (int i = 0; i < 5; i++) begin
      s = (i == 4) ? 5'h00 : 5'($urandom());
      power_up(1'b0, s, i != 4, 1'b0);
      note(0, 1'b0, 0);
      note(1, 1'b0, 0);
      for (int b = 2; b < 7; b++) note(b, s[b - 2], 0);
      note(10, 1'b1, 0);
      drain();
      // later pin moves and writes must change no strap, bypass or pin drive output
      dval = ~dval;
      den = 4'hF;
      mode = ~mode;
      wr(1'b0, 1'b0);
      repeat (12) @(posedge mclk);
      for (int b = 2; b < 7; b++) note(b, s[b - 2], 0);
      note(1, 1'b0, 0);
      for (int b = 13; b < 17; b++) note(b, 1'b0, 0);
      drain();
    end
    // channel on: pins left to pullups, straps must read as off
    power_up(1'b1, 5'h00, 1'b0, 1'b1);
    note(0, 1'b1, 0);
    for (int b = 2; b < 7; b++) note(b, 1'b0, 0);
    drain();
    for (int m = 0; m < 4; m++) begin
      mode = ~mode;
      note(1, mode, 5);
      drain();
    end
    for (int w = 0; w < 2; w++) begin
      wr(w[0], ~w[0]);
      note(13, ~w[0], 4);
      note(14, w[0], 4);
      note(8, w[0], 8);
      note(9, ~w[0], 8);
      drain();
    end
    wr(1'b1, 1'b1);
    rx_pl = 1'b1;
    tx_pl = 1'b1;
    note(15, 1'b1, 4);
    note(16, 1'b1, 4);
    note(10, 1'b0, 8);
    drain();
    rx_pl = 1'b0;
    tx_pl = 1'b0;
    note(11, 1'b1, 8);
    drain();
    // far end pulls the tx line low on its own
    den[3] = 1'b1;
    note(11, 1'b0, 8);
    drain();
    den[3] = 1'b0;
    // forwarded input, changes spaced by the full bound
    for (int k = 0; k < 3; k++) begin
      gen_input_line = ~gen_input_line;
      note(12, gen_input_line, int'(strap_cfg_pkg::FWD_MAX_CYCLES));
      drain();
      repeat (strap_cfg_pkg::FWD_MAX_CYCLES) @(posedge mclk);
      #2;
    end
    wrap_up();
  end
endmodule : deser_strap_config_mux_tb_top
